// >>> design/pslr_pkg.sv
// constants, types and the latency decode for the pseudo-static dram latency/refresh control
// assumes a 100 MHz reference clock that samples the memory bus pins
package pslr_pkg;

   // command-address framing, six bytes on both clock edges
   localparam int unsigned CA_EDGES  = 6;
   localparam int unsigned REG_BYTES = 2;
   localparam int unsigned CA_BITS   = 48;

   // latency_drive_config fields
   localparam int unsigned CR0_LAT_LO   = 4;
   localparam int unsigned CR0_LAT_HI   = 7;
   localparam int unsigned CR0_FIXED    = 3;
   localparam int unsigned CR0_DRV_LO   = 12;
   localparam int unsigned CR0_DRV_HI   = 14;
   localparam logic [3:0]  LAT_CODE_RST = 4'h1;   // selects 6 clocks
   localparam logic [2:0]  DRV_CODE_RST = 3'h0;
   localparam logic [15:0] CR0_RESET    = 16'h0018;

   // refresh_interval_config codes, read-only
   localparam logic [1:0]  RI_DEFAULT = 2'h2;
   localparam logic [1:0]  RI_X1P5    = 2'h3;
   localparam logic [1:0]  RI_X2      = 2'h0;
   localparam logic [1:0]  RI_X4      = 2'h1;

   // register select: lowest address bit picks the second register
   localparam int unsigned REG_SEL_BIT = 0;

   // latency edges per clock and double-latency factor
   localparam int unsigned EDGES_PER_CLK = 2;
   localparam int unsigned LAT_PERIODS   = 2;

   // distributed refresh timing
   localparam int unsigned CLK_MHZ           = 100;
   localparam int unsigned REFRESH_WINDOW_MS = 64;
   localparam int unsigned ARRAY_ROWS        = 16384;
   localparam int unsigned ROW_PERIOD_CYC    = (REFRESH_WINDOW_MS * 1000 * CLK_MHZ) / ARRAY_ROWS;
   localparam int unsigned REFRESH_BUSY_CYC  = 4;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CA    = 3'b001,
      ST_LAT   = 3'b010,
      ST_RREG  = 3'b011,
      ST_DATA  = 3'b100,
      ST_WREG  = 3'b101,
      ST_DONE  = 3'b110
   } pslr_state_t;

   typedef struct packed {
      logic        read;
      logic        reg_space;
      logic        linear;
      logic [44:0] addr;
   } pslr_ca_t;

   typedef struct packed {
      logic [7:0] dq;
      logic       dq_oe_n;
      logic       strobe_mask_line;
      logic       strobe_mask_oe_n;
   } pslr_pins_t;

   // latency field to clock count, 3 to 8 clocks
   function automatic logic [3:0] pslr_lat_clocks(input logic [3:0] code);
      logic [3:0] n;
      case (code)
         4'he:    n = 4'h3;
         4'hf:    n = 4'h4;
         4'h0:    n = 4'h5;
         4'h1:    n = 4'h6;
         4'h2:    n = 4'h7;
         4'h3:    n = 4'h8;
         default: n = 4'h6;
      endcase
      return n;
   endfunction

endpackage

// >>> design/pslr_ctrl.sv
// latency, configuration and hidden refresh control of the memory device bus end
// assumes bus pins arrive asynchronously and are oversampled by i_ref_clk
// How it works
// - reads, writes and register reads wait 6 to 16 clocks from latency field
// - reset latency field selects 6 clocks
// - pending or running refresh raises strobe line during command-address
// - register writes take data right after command-address, zero latency
// - refresh may run while register write data is captured
// - latency is always twice the selected clock count
// - fixed bit set drives strobe line high in every latency-bearing command-address
// - fixed-latency bit is set after reset
// - drive-strength field picks output impedance, reset value zero
// - refresh only starts when idle or while register write data is captured
// - single-row refreshes spread evenly over window, 16384 rows
// - second register low bits report refresh interval code, rest reserved
// - while deselected, interface ignores everything but select and reset
`timescale 1ns/10ps
module pslr_ctrl
   import pslr_pkg::*;
#(
   parameter logic [1:0] REFRESH_CODE = pslr_pkg::RI_DEFAULT
) (
   input  wire logic                 i_ref_clk,        // 100 MHz reference clock
   input  wire logic                 i_rst,            // synchronous reset, high
   input  wire logic                 i_ck,             // bus clock pin
   input  wire logic                 i_cs_n,           // chip select pin, low active
   input  wire logic [7:0]           i_dq,             // data/command pins
   output      pslr_pkg::pslr_pins_t o_pins,           // dq and strobe drive, enables low active
   output      logic [2:0]           o_drive_strength, // output impedance select
   output      logic                 o_busy,           // host access in progress
   output      logic                 o_refresh_strobe, // one-cycle row refresh
   output      logic [13:0]          o_refresh_row     // row being refreshed
);
   import pslr_pkg::*;

   localparam logic [5:0] CA_LAST  = 6'(CA_EDGES - 1);
   localparam logic [5:0] REG_LAST = 6'(REG_BYTES - 1);

   // pin synchronisers; third ck stage only for edge detection
   logic       ck_s1_q, ck_s2_q, ck_s3_q, cs_s1_q, cs_s2_q;
   logic [7:0] dq_s1_q, dq_s2_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
      end else begin
         ck_s1_q <= i_ck;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         cs_s1_q <= i_cs_n;
         cs_s2_q <= cs_s1_q;
         dq_s1_q <= i_dq;
         dq_s2_q <= dq_s1_q;
      end
   end

   logic ck_edge;
   logic selected;
   assign ck_edge  = ck_s2_q ^ ck_s3_q;
   assign selected = ~cs_s2_q;

   // bus state
   pslr_state_t st_q, st_d;
   logic [5:0]  cnt_q, cnt_d;
   logic [47:0] ca_q, ca_d;
   pslr_ca_t    ca_now;
   logic [15:0] cr0_q, cr0_d;
   logic [15:0] wdat_q, wdat_d;
   logic        rsel_q, rsel_d;
   pslr_pins_t  pins_q, pins_d;
   logic        busy_q, busy_d;
   logic [5:0]  lat_edges;
   logic [15:0] reg_rd;
   logic [47:0] ca_shift;

   // refresh state
   logic        pend_q, pend_d;
   logic [2:0]  rbusy_q, rbusy_d;
   logic [11:0] tmr_q, tmr_d;
   logic [11:0] period;
   logic [13:0] row_q, row_d;
   logic        strobe_q, strobe_d;
   logic        fire, start, blocked;

   // double latency always applies on this two-die part
   assign lat_edges = 6'(pslr_lat_clocks(cr0_q[CR0_LAT_HI:CR0_LAT_LO])
                      * LAT_PERIODS * EDGES_PER_CLK);
   assign ca_shift  = {ca_q[39:0], dq_s2_q};
   assign ca_now    = pslr_ca_t'(ca_shift);
   // second register: reserved bits read zero
   assign reg_rd    = rsel_q ? {14'h0000, REFRESH_CODE} : cr0_q;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      ca_d   = ca_q;
      cr0_d  = cr0_q;
      wdat_d = wdat_q;
      rsel_d = rsel_q;
      pins_d = pins_q;
      case (st_q)
         ST_IDLE: begin
            if (selected) begin
               st_d  = ST_CA;
               cnt_d = 6'h00;
               ca_d  = 48'h000000000000;
               // refresh need is flagged up front so host can plan latency
               pins_d.strobe_mask_line = cr0_q[CR0_FIXED] | pend_q
                                         | (rbusy_q != 3'h0);
               pins_d.strobe_mask_oe_n = 1'b0;
            end
         end
         ST_CA: begin
            if (ck_edge) begin
               ca_d  = ca_shift;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == CA_LAST) begin
                  cnt_d  = 6'h00;
                  rsel_d = ca_now.addr[REG_SEL_BIT];
                  if (!ca_now.read && ca_now.reg_space) begin
                     // zero latency: no turnaround, let go of strobe line
                     st_d = ST_WREG;
                     pins_d.strobe_mask_oe_n = 1'b1;
                  end else begin
                     st_d = ST_LAT;
                     pins_d.strobe_mask_line = 1'b0;
                     pins_d.strobe_mask_oe_n = ~ca_now.read;
                  end
               end
            end
         end
         ST_LAT: begin
            if (ck_edge) begin
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == lat_edges - 6'h01) begin
                  cnt_d = 6'h00;
                  if (ca_q[CA_BITS-1] && ca_q[CA_BITS-2]) begin
                     st_d = ST_RREG;
                     pins_d.dq               = reg_rd[15:8];
                     pins_d.dq_oe_n          = 1'b0;
                     pins_d.strobe_mask_line = 1'b1;
                  end else begin
                     st_d = ST_DATA;
                  end
               end
            end
         end
         ST_RREG: begin
            if (ck_edge) begin
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == 6'h00) begin
                  pins_d.dq               = reg_rd[7:0];
                  pins_d.strobe_mask_line = 1'b0;
               end else begin
                  st_d = ST_DONE;
                  pins_d.dq_oe_n          = 1'b1;
                  pins_d.strobe_mask_oe_n = 1'b1;
               end
            end
         end
         ST_WREG: begin
            if (ck_edge) begin
               wdat_d = {wdat_q[7:0], dq_s2_q};
               cnt_d  = cnt_q + 6'h01;
               if (cnt_q == REG_LAST) begin
                  st_d = ST_DONE;
                  if (!rsel_q) begin
                     cr0_d = {wdat_q[7:0], dq_s2_q};
                  end
                  // second register is read-only: write dropped
               end
            end
         end
         ST_DATA: begin
            // array data path lies outside this block
         end
         ST_DONE: begin
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      // deselect releases every pin and abandons the transaction
      if (!selected) begin
         st_d                    = ST_IDLE;
         pins_d.dq_oe_n          = 1'b1;
         pins_d.strobe_mask_oe_n = 1'b1;
         pins_d.strobe_mask_line = 1'b0;
      end
   end

   always_comb begin
      busy_d = (st_d != ST_IDLE);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_q   <= ST_IDLE;
         cnt_q  <= 6'h00;
         ca_q   <= 48'h000000000000;
         cr0_q  <= CR0_RESET;
         wdat_q <= 16'h0000;
         rsel_q <= 1'b0;
         pins_q <= '{dq: 8'h00, dq_oe_n: 1'b1, strobe_mask_line: 1'b0,
                     strobe_mask_oe_n: 1'b1};
         busy_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         ca_q   <= ca_d;
         cr0_q  <= cr0_d;
         wdat_q <= wdat_d;
         rsel_q <= rsel_d;
         pins_q <= pins_d;
         busy_q <= busy_d;
      end
   end

   // row period scales with the reported interval code
   always_comb begin
      case (REFRESH_CODE)
         RI_X1P5: period = 12'((ROW_PERIOD_CYC * 3) / 2);
         RI_X2:   period = 12'(ROW_PERIOD_CYC * 2);
         RI_X4:   period = 12'(ROW_PERIOD_CYC * 4);
         default: period = 12'(ROW_PERIOD_CYC);
      endcase
   end

   // reads and writes block refresh; register write data capture does not
   assign blocked = (st_q != ST_IDLE) && (st_q != ST_WREG);
   assign fire    = (tmr_q == period - 12'h001);
   assign start   = pend_q && (rbusy_q == 3'h0) && !blocked;

   always_comb begin
      tmr_d    = fire ? 12'h000 : tmr_q + 12'h001;
      // a new tick wins over the clear from the refresh it queued behind
      pend_d   = fire | (pend_q & ~start);
      rbusy_d  = (rbusy_q != 3'h0) ? rbusy_q - 3'h1 : rbusy_q;
      row_d    = row_q;
      strobe_d = 1'b0;
      if (start) begin
         // one row per tick, never a burst
         rbusy_d  = 3'(REFRESH_BUSY_CYC);
         row_d    = row_q + 14'h0001;
         strobe_d = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         tmr_q    <= 12'h000;
         pend_q   <= 1'b0;
         rbusy_q  <= 3'h0;
         row_q    <= 14'h3fff;
         strobe_q <= 1'b0;
      end else begin
         tmr_q    <= tmr_d;
         pend_q   <= pend_d;
         rbusy_q  <= rbusy_d;
         row_q    <= row_d;
         strobe_q <= strobe_d;
      end
   end

   assign o_pins           = pins_q;
   assign o_drive_strength = cr0_q[CR0_DRV_HI:CR0_DRV_LO];
   assign o_busy           = busy_q;
   assign o_refresh_strobe = strobe_q;
   assign o_refresh_row    = row_q;

endmodule

// >>> tb/pslr_ctrl_props.sv
// port checker for the latency and refresh control
// assumes it is bound onto pslr_ctrl, one clock domain
`timescale 1ns/10ps
module pslr_ctrl_props
   import pslr_pkg::*;
#(
   parameter logic [1:0] REFRESH_CODE = RI_DEFAULT
) (
   input wire logic        i_ref_clk,        // clock
   input wire logic        i_rst,            // reset
   input wire logic        i_cs_n,           // select
   input wire pslr_pins_t  o_pins,           // pin drive
   input wire logic [2:0]  o_drive_strength, // impedance
   input wire logic        o_busy,           // access
   input wire logic        o_refresh_strobe, // refresh
   input wire logic [13:0] o_refresh_row     // row
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   // sync delay of the select pin sets the margins
   property p_idle_pins;
      i_cs_n [*6] |-> o_pins.dq_oe_n && o_pins.strobe_mask_oe_n;
   endproperty
   a_idle_pins: assert property (p_idle_pins) else $error("pins driven in standby");
   property p_idle_busy;
      i_cs_n [*7] |-> !o_busy;
   endproperty
   a_idle_busy: assert property (p_idle_busy) else $error("busy in standby");
   property p_ca_strobe;
      $fell(i_cs_n) |-> ##[2:6] (!o_pins.strobe_mask_oe_n || i_cs_n);
   endproperty
   a_ca_strobe: assert property (p_ca_strobe) else $error("no strobe in command");
   property p_busy_rise;
      $fell(i_cs_n) |-> ##[2:6] (o_busy || i_cs_n);
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("select not taken");
   property p_dq_busy;
      !o_pins.dq_oe_n |-> o_busy;
   endproperty
   a_dq_busy: assert property (p_dq_busy) else $error("dq driven while idle");
   property p_single_row;
      o_refresh_strobe |=> !o_refresh_strobe [*8];
   endproperty
   a_single_row: assert property (p_single_row) else $error("refresh burst");
   property p_row_step;
      o_refresh_strobe |-> o_refresh_row == $past(o_refresh_row) + 14'h1;
   endproperty
   a_row_step: assert property (p_row_step) else $error("row skipped");
   property p_drv_hold;
      !o_busy && !$past(o_busy) |-> $stable(o_drive_strength);
   endproperty
   a_drv_hold: assert property (p_drv_hold) else $error("drive changed idle");
endmodule
bind pslr_ctrl pslr_ctrl_props #(.REFRESH_CODE(REFRESH_CODE)) u_props (.i_ref_clk(i_ref_clk),
   .i_rst(i_rst), .i_cs_n(i_cs_n), .o_pins(o_pins), .o_drive_strength(o_drive_strength),
   .o_busy(o_busy), .o_refresh_strobe(o_refresh_strobe), .o_refresh_row(o_refresh_row));

// >>> tb/pslr_host_model.sv
// host controller model driving the memory bus pins
// assumes callers run on i_ref_clk; ck rests low between frames
`timescale 1ns/10ps
module pslr_host_model
   import pslr_pkg::*;
(
   input  wire logic       i_ref_clk, // clock
   input  wire pslr_pins_t i_pins,    // device drive
   output      logic       o_ck,      // bus clock
   output      logic       o_cs_n,    // select
   output      logic [7:0] o_dq       // bytes
);
   import pslr_pkg::*;
   initial begin
      o_ck = 1'b0;
      o_cs_n = 1'b1;
      o_dq = 8'h5a;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   // half period of 5 cycles, dq settled 2 cycles ahead of each edge
   task automatic edge_out(input logic [7:0] b);
      o_dq = b;
      wt(2);
      o_ck = ~o_ck;
      wt(3);
   endtask
   // released dq toggles each edge so no stale byte looks valid
   task automatic noise(input int n);
      repeat (n) edge_out(~o_dq);
   endtask
   task automatic xfer(input logic rd, input logic sel, input logic [15:0] wd,
                       input int lat, output logic stb, output logic [15:0] q);
      pslr_ca_t ca;
      ca = '{read: rd, reg_space: 1'b1, linear: 1'b0, addr: 45'(sel)};
      q = 16'h0;
      o_cs_n = 1'b0;
      wt(5);
      stb = i_pins.strobe_mask_line & ~i_pins.strobe_mask_oe_n;
      for (int i = 5; i >= 0; i--) begin
         edge_out(ca[i*8 +: 8]);
      end
      if (!rd) begin
         edge_out(wd[15:8]);
         edge_out(wd[7:0]);
      end else begin
         noise(lat);
         wt(3);
         q[15:8] = i_pins.dq;
         noise(1);
         wt(3);
         q[7:0] = i_pins.dq;
         noise(1);
      end
      o_cs_n = 1'b1;
      o_dq = ~o_dq;
      wt(4);
   endtask
endmodule

// >>> tb/pslr_ctrl_tb.sv
// self-checking bench for pslr_ctrl behind a host model
// assumes 100 MHz clock and default refresh code
`timescale 1ns/10ps
module pslr_ctrl_tb;
   import pslr_pkg::*;
   logic        i_ref_clk;
   logic        i_rst;
   logic        ck;
   logic        cs_n;
   logic [7:0]  dq;
   pslr_pins_t  pins;
   logic [2:0]  drv;
   logic        busy;
   logic        rf_stb;
   logic [13:0] rf_row;
   int          error_cnt = 0;
   int          n_checks = 0;
   logic        stb;
   logic [15:0] q;
   int          l6 = 6 * LAT_PERIODS * EDGES_PER_CLK;
   pslr_ctrl uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ck(ck), .i_cs_n(cs_n),
      .i_dq(dq), .o_pins(pins), .o_drive_strength(drv), .o_busy(busy),
      .o_refresh_strobe(rf_stb), .o_refresh_row(rf_row));
   pslr_host_model host (.i_ref_clk(i_ref_clk), .i_pins(pins), .o_ck(ck), .o_cs_n(cs_n),
      .o_dq(dq));
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic stop_test();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wait_stb(output int n);
      n = 0;
      do begin
         host.wt(1);
         n++;
      end while (rf_stb !== 1'b1 && n < 2000);
   endtask
   task automatic t_reset();
      check({13'h0, drv}, 16'h0, "drive reset");
      check({pins.dq_oe_n, pins.strobe_mask_oe_n, busy}, 16'h6, "idle pins");
   endtask
   task automatic t_default();
      host.xfer(1'b1, 1'b0, 16'h0, l6, stb, q);
      check(q, CR0_RESET, "cfg0 reset");
      check({15'h0, stb}, 16'h1, "fixed flag");
   endtask
   task automatic t_write();
      host.xfer(1'b0, 1'b0, 16'h50e0, 0, stb, q);
      check({13'h0, drv}, 16'h5, "drive field");
      host.xfer(1'b1, 1'b0, 16'h0, 12, stb, q);
      check(q, 16'h50e0, "short latency");
   endtask
   task automatic t_standby();
      host.noise(8);
      check({12'h0, drv, busy}, 16'ha, "standby");
   endtask
   task automatic t_cfg1();
      host.xfer(1'b1, 1'b1, 16'h0, 12, stb, q);
      check(q, {14'h0, RI_DEFAULT}, "interval code");
      host.xfer(1'b0, 1'b1, 16'hffff, 0, stb, q);
      host.xfer(1'b1, 1'b1, 16'h0, 12, stb, q);
      check(q, {14'h0, RI_DEFAULT}, "cfg1 write");
   endtask
   task automatic t_refresh();
      int n;
      logic [13:0] r;
      wait_stb(n);
      r = rf_row;
      wait_stb(n);
      check(16'(n), 16'(ROW_PERIOD_CYC), "refresh spacing");
      check({2'h0, rf_row}, {2'h0, r + 14'h1}, "row step");
      host.xfer(1'b1, 1'b1, 16'h0, 12, stb, q);
      check({15'h0, stb}, 16'h1, "refresh flag");
      check(q, {14'h0, RI_DEFAULT}, "read behind refresh");
      wait_stb(n);
      host.xfer(1'b0, 1'b0, 16'h0028, 0, stb, q);
      host.xfer(1'b1, 1'b0, 16'h0, 28, stb, q);
      check(q, 16'h0028, "write beside refresh");
   endtask
   initial begin
      #300us;
      error_cnt++;
      stop_test();
   end
   initial begin
      i_rst = 1'b1;
      host.wt(16);
      i_rst = 1'b0;
      host.wt(3);
      t_reset();
      t_default();
      t_write();
      t_standby();
      t_cfg1();
      t_refresh();
      stop_test();
   end
endmodule
